// [dv/interval_event_timer_properties.sv]
/*
  checker on the bit-serial bus between the host end and the device end.
  assumes the bench hands it the interface signals and hclk/hresetn.
*/
module interval_event_timer_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [4:0] bit_select,
  input wire logic ce_n,
  input wire logic serial_write_strobe,
  input wire logic serial_read_oe,
  input wire logic irq_request_n,
  input wire logic [3:0] irq_level_code,
  input wire logic power_up_reset_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // read wire released whenever the chip is not enabled
  chk_read_oe_ce:
    assert property (serial_read_oe == !ce_n) else $error("oe wrong");
  // a transfer holds chip enable low for exactly two cycles
  chk_ce_two:
    assert property ($fell(ce_n) |=> !ce_n ##1 ce_n)
    else $error("chip enable length wrong");
  // strobe only in the second cycle of an enabled transfer
  chk_strobe_ce:
    assert property (serial_write_strobe |-> !ce_n && !$past(ce_n))
    else $error("strobe outside transfer");
  chk_strobe_pulse:
    assert property (serial_write_strobe |=> !serial_write_strobe)
    else $error("strobe too long");
  // the address may not move inside a transfer
  chk_sel_stable:
    assert property (!ce_n && !$past(ce_n) |-> $stable(bit_select))
    else $error("select moved");
  // power-up reset forces code zero with the request held high
  chk_por_code:
    assert property (!power_up_reset_n |=>
      irq_level_code == 4'h0 && irq_request_n)
    else $error("reset code wrong");
  chk_idle_code:
    assert property (irq_request_n && power_up_reset_n &&
      $past(power_up_reset_n) |-> irq_level_code == 4'hf)
    else $error("idle code wrong");
  chk_por_hold:
    assert property ($rose(power_up_reset_n) |->
      !$past(power_up_reset_n, 2))
    else $error("reset pulse short");
endmodule

// [dv/interval_event_timer_tb.sv]
/*
  bench: ahb-lite master on the host end, which drives the device end
  over the interface; expectations come from a small model here.
  assumes the design files and the shared header are compiled first.
*/
`include "serial_timer_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module interval_event_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:1] irq_input_n = 15'h7fff;
  logic [15:0] pin_drive = 16'ha5c3;
  logic [15:0] port_in;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic timer_enabled;
  logic [31:0] rd;
  logic [15:0] oe_m;
  logic [15:0] out_m;
  logic [13:0] cap;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int t1;
  int k;
  io_bus_if bus();

  bus_host_controller u_bus_host_controller (.hclk(hclk),
    .hresetn(hresetn), .bus(bus.host), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  interval_event_timer u_interval_event_timer (.hclk(hclk),
    .hresetn(hresetn), .bus(bus.device), .irq_input_n(irq_input_n),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .timer_enabled(timer_enabled));
  interval_event_timer_properties u_interval_event_timer_properties (
    .hclk(hclk), .hresetn(hresetn), .bit_select(bus.bit_select),
    .ce_n(bus.ce_n), .serial_write_strobe(bus.serial_write_strobe),
    .serial_read_oe(bus.serial_read_oe), .irq_request_n(bus.irq_request_n),
    .irq_level_code(bus.irq_level_code),
    .power_up_reset_n(bus.power_up_reset_n));

  // a driven port shows its own value, else the bench's pin level
  assign port_in = (port_oe & port_out) | (~port_oe & pin_drive);

  initial begin
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) cyc <= cyc + 1;

  // one single-word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // one serial bit transfer; ends with status idle, read bit in rd[1]
  task automatic ser(input logic w, input logic [4:0] b, input logic v);
    ahb(1'b1, `OFS_COMMAND, {22'h0, w, v, 3'h0, b});
    repeat (2) @(posedge hclk);
    ahb(1'b0, `OFS_STATUS, 32'h0);
    repeat (20) if (rd[0] !== 1'b0) ahb(1'b0, `OFS_STATUS, 32'h0);
  endtask

  // model of the encoder with every mask on: lowest active line wins
  function automatic logic [3:0] top_code(input logic [15:1] n);
    logic [3:0] c;
    c = 4'hf;
    for (int b = 15; b >= 1; b--) if (!n[b]) c = 4'(b);
    return c;
  endfunction

  // bounded wait for the request line; the watchdog catches the rest
  task automatic wait_irq();
    repeat (1000) if (bus.irq_request_n !== 1'b0) @(posedge hclk);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    repeat (40000) @(posedge hclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    void'($urandom(78379));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    `CHK(port_oe, 16'h0)
    `CHK(timer_enabled, 1'b0)
    // interrupt mode: bits 1-15 read back the pins, masks still off
    irq_input_n <= 15'($urandom);
    repeat (4) @(posedge hclk);
    ser(1'b0, `BIT_MODE, 1'b0);
    `CHK(rd[1], 1'b0)
    for (int b = 1; b < 16; b++) begin
      ser(1'b0, 5'(b), 1'b0);
      `CHK(rd[1], irq_input_n[b])
    end
    `CHK(bus.irq_level_code, `CODE_NONE)
    // all masks on, then random pin patterns through the encoder
    for (int b = 1; b < 16; b++) ser(1'b1, 5'(b), 1'b1);
    for (int i = 0; i < 6; i++) begin
      irq_input_n <= (i == 0) ? 15'h7fff : 15'($urandom);
      repeat (5) @(posedge hclk);
      `CHK(bus.irq_level_code, top_code(irq_input_n))
      `CHK(bus.irq_request_n, &irq_input_n)
    end
    irq_input_n <= 15'h7fff;
    // port writes turn ports to outputs; soft reset turns them back
    oe_m = 16'h0;
    out_m = 16'h0;
    for (int i = 0; i < 4; i++) begin
      k = $urandom_range(15);
      ser(1'b1, 5'(16 + k), 1'(i));
      oe_m[k] = 1'b1;
      out_m[k] = 1'(i);
    end
    `CHK(port_oe, oe_m)
    `CHK(port_out & oe_m, out_m)
    ser(1'b0, 5'(16 + k), 1'b0);
    `CHK(rd[1], out_m[k])
    // every mask off while the timer is set up and read back
    for (int b = 1; b < 16; b++) ser(1'b1, 5'(b), 1'b0);
    ser(1'b1, `BIT_MODE, 1'b1);
    ser(1'b1, `BIT_SOFT_RESET, 1'b1);
    `CHK(port_oe, 16'h0)
    // start value 5: bit 3 then bit 1, restart, capture at once
    ser(1'b1, 5'h03, 1'b1);
    ser(1'b1, 5'h01, 1'b1);
    `CHK(timer_enabled, 1'b1)
    irq_input_n <= 15'h7ffb;
    ser(1'b1, 5'h03, 1'b1);
    ser(1'b1, `BIT_MODE, 1'b1);
    for (int b = 1; b < 15; b++) begin
      ser(1'b0, 5'(b), 1'b0);
      cap[b - 1] = rd[1];
    end
    `CHK(cap, 14'h0005)
    // mask 3 alone back on, long before the first expiry
    ser(1'b1, `BIT_MODE, 1'b0);
    ser(1'b1, `BIT_CLK_CLEAR, 1'b1);
    repeat (4) @(posedge hclk);
    `CHK(bus.irq_level_code, `CODE_NONE)
    wait_irq();
    t1 = cyc;
    `CHK(bus.irq_level_code, 4'h3)
    ser(1'b1, `BIT_MODE, 1'b1);
    ser(1'b0, 5'h0f, 1'b0);
    `CHK(rd[1], 1'b1)
    // clearing via mask 3; the low level-3 pin must stay hidden
    ser(1'b1, `BIT_MODE, 1'b0);
    ser(1'b1, `BIT_CLK_CLEAR, 1'b1);
    repeat (4) @(posedge hclk);
    `CHK(bus.irq_request_n, 1'b1)
    wait_irq();
    `CHK(cyc - t1, 5 * 64)
    ser(1'b1, `BIT_CLK_CLEAR, 1'b1);
    irq_input_n <= 15'h7fff;
    // zero start value stops the timer
    ser(1'b1, `BIT_MODE, 1'b1);
    ser(1'b1, 5'h01, 1'b0);
    ser(1'b1, 5'h03, 1'b0);
    `CHK(timer_enabled, 1'b0)
    // a power-up reset pulse in mid-run undoes timer, port and mode
    ser(1'b1, 5'h01, 1'b1);
    ser(1'b1, 5'h10, 1'b1);
    `CHK(timer_enabled, 1'b1)
    `CHK(port_oe, 16'h0001)
    ahb(1'b1, `OFS_RESET, 32'h00000001);
    repeat (4) @(posedge hclk);
    `CHK(timer_enabled, 1'b0)
    `CHK(port_oe, 16'h0)
    ser(1'b0, `BIT_MODE, 1'b0);
    `CHK(rd[1], 1'b0)
    `CHK(hresp, 1'b0)
    print_verdict();
  end
endmodule

// [hdl/bus_host_controller.sv]
/*
  host end: an ahb-lite slave whose command register drives single bit
  reads and writes on the bit-serial io bus, plus the power-up reset.
  assumes the device shares hclk and answers reads one edge after select.
*/
`include "serial_timer_params.svh"

module bus_host_controller (
  input wire logic hclk,
  input wire logic hresetn,
  io_bus_if.host bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  serial_timer_pkg::host_state_e state;
  serial_timer_pkg::host_state_e next_state;
  logic dphase_wr;
  logic [7:0] dphase_addr;
  logic [4:0] sel;
  logic ce_n;
  logic wdata;
  logic strobe;
  logic is_write;
  logic rdata;
  logic por_n;
  logic [1:0] por_cnt;
  logic next_dphase_wr;
  logic [7:0] next_dphase_addr;
  logic [31:0] next_hrdata;
  logic [4:0] next_sel;
  logic next_ce_n;
  logic next_wdata;
  logic next_strobe;
  logic next_is_write;
  logic next_rdata;
  logic next_por_n;
  logic [1:0] next_por_cnt;
  logic accept;

  // zero wait states; hsize is unused since only words are mapped
  assign accept = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_dphase_wr = accept & hwrite;
    next_dphase_addr = haddr[7:0];
    next_hrdata = hrdata;
    next_state = state;
    next_sel = sel;
    next_ce_n = ce_n;
    next_wdata = wdata;
    next_strobe = 1'b0;
    next_is_write = is_write;
    next_rdata = rdata;
    next_por_n = por_n;
    next_por_cnt = por_cnt;
    // read data is set up at the address phase edge
    if (accept & ~hwrite) begin
      if (haddr[7:0] == `OFS_STATUS) begin
        next_hrdata = {24'h000000, bus.irq_level_code, 1'b0,
                       bus.irq_request_n, rdata,
                       state != serial_timer_pkg::st_idle};
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
    // power-up reset pulse held for a fixed count
    if (!por_n) begin
      next_por_cnt = 2'(por_cnt + 2'h1);
      if (por_cnt == `POR_HOLD_CYCLES - 2'h1) begin
        next_por_n = 1'b1;
      end
    end
    if (dphase_wr && dphase_addr == `OFS_RESET &&
        hwdata[`RESET_GO_POS]) begin
      next_por_n = 1'b0;
      next_por_cnt = 2'h0;
    end
    case (state)
      serial_timer_pkg::st_idle: begin
        if (dphase_wr && dphase_addr == `OFS_COMMAND) begin
          next_sel = hwdata[`CMD_ADDR_LSB +: 5];
          next_wdata = hwdata[`CMD_DATA_POS];
          next_is_write = hwdata[`CMD_WRITE_POS];
          next_ce_n = 1'b0;
          next_state = serial_timer_pkg::st_select;
        end
      end
      serial_timer_pkg::st_select: begin
        if (is_write) begin
          next_strobe = 1'b1;
          next_state = serial_timer_pkg::st_strobe;
        end else begin
          next_state = serial_timer_pkg::st_wait;
        end
      end
      serial_timer_pkg::st_strobe: begin
        next_ce_n = 1'b1;
        next_state = serial_timer_pkg::st_idle;
      end
      serial_timer_pkg::st_wait: begin
        next_rdata = bus.serial_read_data;
        next_ce_n = 1'b1;
        next_state = serial_timer_pkg::st_idle;
      end
      default: begin
        next_ce_n = 1'b1;
        next_state = serial_timer_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= serial_timer_pkg::st_idle;
      dphase_wr <= 1'b0;
      dphase_addr <= 8'h00;
      hrdata <= 32'h00000000;
      sel <= 5'h00;
      ce_n <= 1'b1;
      wdata <= 1'b0;
      strobe <= 1'b0;
      is_write <= 1'b0;
      rdata <= 1'b0;
      por_n <= 1'b0;
      por_cnt <= 2'h0;
    end else begin
      state <= next_state;
      dphase_wr <= next_dphase_wr;
      dphase_addr <= next_dphase_addr;
      hrdata <= next_hrdata;
      sel <= next_sel;
      ce_n <= next_ce_n;
      wdata <= next_wdata;
      strobe <= next_strobe;
      is_write <= next_is_write;
      rdata <= next_rdata;
      por_n <= next_por_n;
      por_cnt <= next_por_cnt;
    end
  end

  assign bus.bit_select = sel;
  assign bus.ce_n = ce_n;
  assign bus.serial_write_data = wdata;
  assign bus.serial_write_strobe = strobe;
  assign bus.power_up_reset_n = por_n;

endmodule

// [hdl/interval_event_timer.sv]
/*
  device end: interrupt priority encoder, 16 io ports and a 14-bit
  interval/event timer reached over the bit-serial io bus.
  assumes the host runs on hclk, so bus inputs are used unsynchronised;
  interrupt and port pins come from outside and are synchronised.
*/
// Implementation choice: register access over AHB-Lite.
// How it works
// - 14-bit counter decrements every 64 clocks
// - mode bit one selects timer meaning
// - nonzero start value enables and sets interval
// - reaching zero raises interrupt and reloads start
// - any write to mask 3 clears timer interrupt
// - every start bit write restarts the counter
// - power-up reset or zero start disables timer
// - enabled timer replaces level-3 input interrupt
// - host should mask interrupts during timer access
// - entering timer mode captures the counter value
// - timer-mode reads of bits 1-14 return capture
// - bit 0 read returns current mode
// - interrupt-mode reads return interrupt line levels
// - timer-mode bit 15 read shows request active
// - timer-mode write one to bit 15 resets ports
// - host holds power-up reset low two cycles
// - power-up reset clears masks, timer, ports, code
// - request low while any enabled interrupt active
// - code lines carry highest priority, else ones
// - transfers need chip enable; interrupts ignore it
// - read data undriven while chip enable high
// - five select bits address reads and writes
// - code and request registered on next edge
`include "serial_timer_params.svh"

module interval_event_timer (
  input wire logic hclk,
  input wire logic hresetn,
  io_bus_if.device bus,
  input wire logic [15:1] irq_input_n,
  input wire logic [15:0] port_in,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  output logic timer_enabled
);

  logic [15:1] irq_meta;
  logic [15:1] irq_sync;
  logic [15:0] port_meta;
  logic [15:0] port_sync;

  logic mode;
  logic [15:1] mask;
  logic [13:0] start;
  logic [13:0] count;
  logic [5:0] prescale;
  logic [13:0] capture;
  logic timer_irq;
  logic [3:0] code;
  logic req_n;
  logic rd;

  logic next_mode;
  logic [15:1] next_mask;
  logic [13:0] next_start;
  logic [13:0] next_count;
  logic [5:0] next_prescale;
  logic [13:0] next_capture;
  logic next_timer_irq;
  logic next_timer_enabled;
  logic [15:0] next_port_out;
  logic [15:0] next_port_oe;
  logic [3:0] next_code;
  logic next_req_n;
  logic next_rd;

  logic por;
  logic wr;
  logic set_irq;
  logic clear_irq;
  logic [4:0] addr;
  logic [3:0] idx;
  logic [15:1] active;

  // pins from outside the clock domain pass two flops first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_meta <= 15'h7fff;
      irq_sync <= 15'h7fff;
      port_meta <= 16'h0000;
      port_sync <= 16'h0000;
    end else begin
      irq_meta <= irq_input_n;
      irq_sync <= irq_meta;
      port_meta <= port_in;
      port_sync <= port_meta;
    end
  end

  // power-up reset comes from host logic on hclk: no synchroniser
  assign por = ~bus.power_up_reset_n;
  assign wr = ~bus.ce_n & bus.serial_write_strobe;
  assign addr = bus.bit_select;
  assign idx = 4'(addr[3:0] - 4'h1);

  // timer, masks, mode, ports: next values
  always_comb begin
    next_mode = mode;
    next_mask = mask;
    next_start = start;
    next_count = count;
    next_prescale = prescale;
    next_capture = capture;
    next_port_out = port_out;
    next_port_oe = port_oe;
    set_irq = 1'b0;
    clear_irq = 1'b0;
    if (timer_enabled) begin
      next_prescale = 6'(prescale + 6'h01);
      if (prescale == `PRESCALE_LAST) begin
        // zero is reached when a count of one expires
        if (count <= 14'h0001) begin
          next_count = start;
          set_irq = 1'b1;
        end else begin
          next_count = 14'(count - 14'h0001);
        end
      end
    end
    if (wr) begin
      if (addr == `BIT_MODE) begin
        next_mode = bus.serial_write_data;
        if (bus.serial_write_data) begin
          next_capture = count;
        end
      end else if (addr >= `BIT_FIRST_PORT) begin
        next_port_out[addr[3:0]] = bus.serial_write_data;
        next_port_oe[addr[3:0]] = 1'b1;
      end else if (!mode) begin
        next_mask[addr[3:0]] = bus.serial_write_data;
        if (addr == `BIT_CLK_CLEAR) begin
          clear_irq = 1'b1;
        end
      end else if (addr == `BIT_SOFT_RESET) begin
        if (bus.serial_write_data) begin
          next_port_oe = `PORT_RESET;
        end
      end else begin
        next_start[idx] = bus.serial_write_data;
        next_count = next_start;
        next_prescale = 6'h00;
      end
    end
    // a new expiry in the clearing cycle is kept
    next_timer_irq = (timer_irq & ~clear_irq) | set_irq;
    next_timer_enabled = |next_start;
    if (por) begin
      next_mode = 1'b0;
      next_mask = `MASK_RESET;
      next_start = `START_RESET;
      next_count = `START_RESET;
      next_prescale = 6'h00;
      next_timer_irq = 1'b0;
      next_timer_enabled = 1'b0;
      next_port_oe = `PORT_RESET;
      next_port_out = `PORT_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= 1'b0;
      mask <= `MASK_RESET;
      start <= `START_RESET;
      count <= `START_RESET;
      prescale <= 6'h00;
      capture <= 14'h0000;
      timer_irq <= 1'b0;
      timer_enabled <= 1'b0;
      port_out <= `PORT_RESET;
      port_oe <= `PORT_RESET;
    end else begin
      mode <= next_mode;
      mask <= next_mask;
      start <= next_start;
      count <= next_count;
      prescale <= next_prescale;
      capture <= next_capture;
      timer_irq <= next_timer_irq;
      timer_enabled <= next_timer_enabled;
      port_out <= next_port_out;
      port_oe <= next_port_oe;
    end
  end

  // priority encoder; chip enable plays no part here
  always_comb begin
    for (int i = 1; i < 16; i++) begin
      active[i] = mask[i] & ~irq_sync[i];
    end
    if (timer_enabled) begin
      active[3] = mask[3] & timer_irq;
    end
    next_code = `CODE_NONE;
    for (int i = 15; i >= 1; i--) begin
      if (active[i]) begin
        next_code = 4'(i);
      end
    end
    next_req_n = ~|active;
    if (por) begin
      next_code = `CODE_RESET;
      next_req_n = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code <= `CODE_RESET;
      req_n <= 1'b1;
    end else begin
      code <= next_code;
      req_n <= next_req_n;
    end
  end

  // read mux, registered so data lags the select lines by one edge
  always_comb begin
    if (addr == `BIT_MODE) begin
      next_rd = mode;
    end else if (addr >= `BIT_FIRST_PORT) begin
      next_rd = port_sync[addr[3:0]];
    end else if (!mode) begin
      next_rd = irq_sync[addr[3:0]];
    end else if (addr == `BIT_SOFT_RESET) begin
      next_rd = ~req_n;
    end else begin
      next_rd = capture[idx];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd <= 1'b0;
    end else begin
      rd <= next_rd;
    end
  end

  assign bus.serial_read_data = rd;
  assign bus.serial_read_oe = ~bus.ce_n;
  assign bus.irq_level_code = code;
  assign bus.irq_request_n = req_n;

endmodule

// [hdl/io_bus_if.sv]
/*
  the bit-serial io bus with interrupt code lines and power-up reset.
  assumes the bench resolves the read data wire from serial_read_oe.
*/
interface io_bus_if;
  logic [4:0] bit_select;
  logic ce_n;
  logic serial_write_data;
  logic serial_write_strobe;
  logic serial_read_data;
  logic serial_read_oe;
  logic irq_request_n;
  logic [3:0] irq_level_code;
  logic power_up_reset_n;

  modport device (
    input bit_select,
    input ce_n,
    input serial_write_data,
    input serial_write_strobe,
    input power_up_reset_n,
    output serial_read_data,
    output serial_read_oe,
    output irq_request_n,
    output irq_level_code
  );

  modport host (
    output bit_select,
    output ce_n,
    output serial_write_data,
    output serial_write_strobe,
    output power_up_reset_n,
    input serial_read_data,
    input serial_read_oe,
    input irq_request_n,
    input irq_level_code
  );
endinterface

// [hdl/serial_timer_params.svh]
/*
  constants shared by both ends of the bit-serial link: bit addresses,
  timing counts, reset values and the host's own register offsets.
  assumes it is included by its bare name after any package.
*/
`ifndef SERIAL_TIMER_PARAMS_SVH
`define SERIAL_TIMER_PARAMS_SVH

// bit addresses on the select lines
`define BIT_MODE 5'h00
`define BIT_CLK_CLEAR 5'h03
`define BIT_SOFT_RESET 5'h0f
`define BIT_FIRST_PORT 5'h10

// counter prescale: 64 system clocks per decrement
`define PRESCALE_LAST 6'h3f

// interrupt code values
`define CODE_NONE 4'hf
`define CODE_RESET 4'h0

// reset values of the device's state
`define START_RESET 14'h0000
`define MASK_RESET 15'h0000
`define PORT_RESET 16'h0000

// host holds the power-up reset low this many cycles (at least 2)
`define POR_HOLD_CYCLES 2'h2

// host command registers on the ahb-lite side
`define OFS_COMMAND 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESET 8'h08
`define CMD_ADDR_LSB 0
`define CMD_DATA_POS 8
`define CMD_WRITE_POS 9
`define RESET_GO_POS 0

`endif

// [hdl/serial_timer_pkg.sv]
/*
  types used by the host end of the bit-serial link.
  assumes nothing else; every use is written with the package scope.
*/
package serial_timer_pkg;

  // host sequencer for one bit transfer
  typedef enum logic [1:0] {
    st_idle,
    st_select,
    st_strobe,
    st_wait
  } host_state_e;

endpackage
